// ==== rtl/usb_endpoint_interrupt_status.sv ====
// Purpose: Interrupt causes, endpoint status flags, endpoint 1 FIFO and
//          suspend idle timer behind an APB register file.
// Assumes: Protocol engine pulses events for one cycle; clock 10 MHz.
// Notes:   pready follows ce, so accesses stall while the block is frozen.
//          A read whose setup cycle meets ce low returns stale data.
//          Fifo status: empty, full, other flags, fill count, then levels.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "usb_irq_defines.svh"

module usb_endpoint_interrupt_status #(
  parameter int unsigned SUSPEND_IDLE_CYCLES = `SUSPEND_IDLE_US * `CLOCK_MHZ
) (
  input  wire logic                       clock,
  input  wire logic                       arst_n,
  input  wire logic                       ce,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire usb_irq_pkg::usb_events_t   usb_ev,
  input  wire logic [3:0]                 ctrl_rx_count,
  input  wire logic [7:0]                 other_fifo_flags,
  input  wire usb_irq_pkg::ep1_usb_req_t  ep1_usb_req,
  output usb_irq_pkg::ep1_usb_rsp_t       ep1_usb_rsp,
  output logic [1:0]                      endpoint_tx_dir,
  output logic                            dma_request,
  input  wire logic                       dma_ack,
  input  wire logic [7:0]                 dma_wdata,
  output logic [7:0]                      dma_rdata,
  output logic                            interrupt_request_out
);

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr[1:0] == 2'h0) && (addr <= `OFF_EP1_DATA);
  endfunction

  logic        setup_ph;
  logic        wr_acc;
  logic        rd_acc;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [7:0]  enable_reg;
  logic [3:0]  config_reg;
  logic [7:0]  flag_reg;
  logic [7:0]  flag_set;
  logic [7:0]  flag_clr;
  logic [7:0]  raw_cause;
  logic [7:0]  cause_status;
  logic        tx_loaded_reg;
  logic        irq_out_reg;
  logic [3:0]  rx_count_reg;
  logic [15:0] idle_reg;
  logic        suspend_hit;

  logic [7:0]  fifo_mem [`EP1_FIFO_BYTES];
  logic [6:0]  wr_ptr_reg;
  logic [6:0]  rd_ptr_reg;
  logic [6:0]  wr_mark_reg;
  logic [6:0]  rd_mark_reg;
  logic [6:0]  fill;
  logic [1:0]  levels;
  logic        f_full;
  logic        f_empty;
  logic        ep1_tx;
  logic        dma_on;
  logic        cpu_data_wr;
  logic        cpu_data_rd;
  logic        push;
  logic        pop;
  logic [7:0]  push_data;
  logic        fctl_wr;
  logic        wr_enable;
  logic        wr_config;
  logic        wr_ev_clear;
  logic        wr_setup_clr;
  logic        wr_pkt_ready;

  assign setup_ph = psel & ~penable & ce;
  assign wr_acc   = psel & penable & ce & pwrite & mapped(paddr);
  assign rd_acc   = psel & penable & ce & ~pwrite & mapped(paddr);
  // Zero wait states; a frozen block stalls the bus rather than drop an access
  assign pready   = ce;
  assign pslverr  = psel & penable & ~mapped(paddr);
  assign prdata   = prdata_reg;

  // Decoded once here so every process sees the same write strobe
  assign wr_enable    = wr_acc && hit(paddr, `OFF_ENABLE_MASK);
  assign wr_config    = wr_acc && hit(paddr, `OFF_EP_CONFIG);
  assign wr_ev_clear  = wr_acc && hit(paddr, `OFF_EVENT_CLEAR);
  assign wr_setup_clr = wr_acc && hit(paddr, `OFF_CTRL_EP_STATUS);
  assign wr_pkt_ready = wr_acc && hit(paddr, `OFF_PKT_READY);

  // Register bus: control registers

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      enable_reg <= `ENABLE_RESET;
    else if (wr_enable)
      enable_reg <= pwdata[7:0]; // see RULE4
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      config_reg <= `CONFIG_RESET; // see RULE18
    else if (wr_config)
      config_reg <= pwdata[3:0]; // see RULE14
  end

  assign endpoint_tx_dir = {config_reg[`CFG_EP2_TX], config_reg[`CFG_EP1_TX]};
  assign ep1_tx          = config_reg[`CFG_EP1_TX];
  assign dma_on          = config_reg[`CFG_EP1_DMA];

  // Sticky event flags

  always_comb
  begin
    flag_set = 8'h00;
    flag_set[`CAUSE_SETUP]   = usb_ev.setup_done; // see RULE5
    flag_set[`CAUSE_EP1]     = usb_ev.ep1_done;
    flag_set[`CAUSE_EP2]     = usb_ev.ep2_done;
    flag_set[`CAUSE_CTRL_RX] = usb_ev.ctrl_rx_done; // see RULE9 see RULE10
    flag_set[`CAUSE_EP3_TX]  = usb_ev.ep3_tx_done;
    flag_set[`CAUSE_RESET]   = usb_ev.bus_reset;
    flag_set[`CAUSE_SUSPEND] = suspend_hit; // see RULE17
  end

  always_comb
  begin
    // Clears come from the event clear register or the per-flag clear bits
    flag_clr = 8'h00;
    if (wr_ev_clear)
      flag_clr = pwdata[7:0];
    if (wr_setup_clr)
      flag_clr[`CAUSE_SETUP] = flag_clr[`CAUSE_SETUP] | pwdata[0]; // see RULE7
    if (wr_pkt_ready)
    begin
      flag_clr[`CAUSE_CTRL_RX] = flag_clr[`CAUSE_CTRL_RX] | pwdata[`PKT_CTRL_RX]; // see RULE12
      flag_clr[`CAUSE_EP1]     = flag_clr[`CAUSE_EP1] | pwdata[`PKT_EP1];
      flag_clr[`CAUSE_EP2]     = flag_clr[`CAUSE_EP2] | pwdata[`PKT_EP2];
    end
    flag_clr[`CAUSE_CTRL_TX] = 1'b0;
  end

  // New event beats a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) // see RULE2
    begin : g_flag
      always_ff @(posedge clock or negedge arst_n)
      begin
        if (!arst_n)
          flag_reg[gi] <= 1'b0;
        else if (ce && flag_set[gi])
          flag_reg[gi] <= 1'b1; // see RULE8 see RULE19
        else if (ce && flag_clr[gi])
          flag_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  // Transmit cause is a level: data stage open and buffer not yet loaded
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      tx_loaded_reg <= 1'b0;
    else if (ce && usb_ev.ctrl_tx_acked)
      tx_loaded_reg <= 1'b0;
    else if (wr_pkt_ready && pwdata[`PKT_CTRL_TX])
      tx_loaded_reg <= 1'b1;
  end

  always_comb
  begin
    raw_cause = flag_reg;
    raw_cause[`CAUSE_CTRL_TX] = usb_ev.ctrl_tx_stage & ~tx_loaded_reg;
  end

  assign cause_status = raw_cause & enable_reg; // see RULE3 see RULE6 see RULE11

  // Registered so the pin never glitches while causes or enables change
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      irq_out_reg <= 1'b1;
    else if (ce)
      irq_out_reg <= (|cause_status) ~^ config_reg[`CFG_IRQ_HIGH]; // see RULE1 see RULE18
  end

  assign interrupt_request_out = irq_out_reg;

  // Byte count taken with the done pulse and held for the next packet
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      rx_count_reg <= 4'h0;
    else if (ce && usb_ev.ctrl_rx_done)
      rx_count_reg <= ctrl_rx_count;
  end

  // Suspend idle timer, saturates so suspend fires once per idle spell
  assign suspend_hit = usb_ev.bus_idle && (idle_reg == 16'(SUSPEND_IDLE_CYCLES - 1));

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      idle_reg <= 16'h0000;
    else if (ce)
    begin
      if (!usb_ev.bus_idle)
        idle_reg <= 16'h0000;
      else if (idle_reg != 16'(SUSPEND_IDLE_CYCLES))
        idle_reg <= idle_reg + 16'h0001; // see RULE17
    end
  end

  // Endpoint 1 FIFO
  // Levels are only reported; storage is a single 64-byte ring

  assign f_empty     = (wr_ptr_reg == rd_ptr_reg);
  assign f_full      = (fill == 7'(`EP1_FIFO_BYTES));
  assign fill        = wr_ptr_reg - rd_ptr_reg;
  assign levels      = 2'((fill + 7'(`EP1_LEVEL_BYTES - 1)) / 7'(`EP1_LEVEL_BYTES)); // see RULE13
  assign cpu_data_wr = wr_acc && hit(paddr, `OFF_EP1_DATA);
  assign cpu_data_rd = rd_acc && hit(paddr, `OFF_EP1_DATA);
  assign fctl_wr     = wr_acc && hit(paddr, `OFF_FIFO_CONTROL);

  always_comb
  begin
    if (ep1_tx)
    begin
      push      = cpu_data_wr | (dma_on & dma_ack & ce); // see RULE16
      push_data = cpu_data_wr ? pwdata[7:0] : dma_wdata;
      pop       = ep1_usb_req.pop & ce;
    end
    else
    begin
      push      = ep1_usb_req.push & ce;
      push_data = ep1_usb_req.push_data;
      pop       = cpu_data_rd | (dma_on & dma_ack & ce);
    end
  end

  always_ff @(posedge clock)
  begin
    if (push && !f_full)
      fifo_mem[wr_ptr_reg[5:0]] <= push_data;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_reg  <= 7'h00;
      wr_mark_reg <= 7'h00;
    end
    else if (fctl_wr && pwdata[`FCTL_REWIND_WR])
      wr_ptr_reg <= wr_mark_reg; // see RULE15
    else
    begin
      if (push && !f_full)
        wr_ptr_reg <= wr_ptr_reg + 7'h01;
      if (fctl_wr && pwdata[`FCTL_MARK])
        wr_mark_reg <= wr_ptr_reg;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_ptr_reg  <= 7'h00;
      rd_mark_reg <= 7'h00;
    end
    else if (fctl_wr && pwdata[`FCTL_REWIND_RD])
      rd_ptr_reg <= rd_mark_reg; // see RULE15
    else
    begin
      if (pop && !f_empty)
        rd_ptr_reg <= rd_ptr_reg + 7'h01;
      if (fctl_wr && pwdata[`FCTL_MARK])
        rd_mark_reg <= rd_ptr_reg;
    end
  end

  // Head byte is read straight from the array so back-to-back pops stay fresh
  assign ep1_usb_rsp.head_data = fifo_mem[rd_ptr_reg[5:0]];
  assign ep1_usb_rsp.full      = f_full;
  assign ep1_usb_rsp.empty     = f_empty;
  assign dma_rdata             = fifo_mem[rd_ptr_reg[5:0]];
  // Request drops at the FIFO limit, so no DMA beat is refused by a full or empty FIFO
  assign dma_request = dma_on & (ep1_tx ? ~f_full : ~f_empty); // see RULE16

  // Read data captured in the setup phase, shown in the access phase
  always_comb
  begin
    prdata_next = 32'h0000_0000;
    case (paddr)
      `OFF_CAUSE_STATUS:   prdata_next[7:0] = cause_status;
      `OFF_ENABLE_MASK:    prdata_next[7:0] = enable_reg;
      `OFF_CTRL_EP_STATUS: prdata_next[0]   = flag_reg[`CAUSE_SETUP];
      `OFF_PKT_READY:
      begin
        prdata_next[`PKT_CTRL_RX] = flag_reg[`CAUSE_CTRL_RX];
        prdata_next[`PKT_EP1]     = flag_reg[`CAUSE_EP1];
        prdata_next[`PKT_EP2]     = flag_reg[`CAUSE_EP2];
        prdata_next[`PKT_CTRL_TX] = tx_loaded_reg;
      end
      `OFF_RX_BYTE_COUNT:  prdata_next[3:0] = rx_count_reg;
      `OFF_EP_CONFIG:      prdata_next[3:0] = config_reg;
      `OFF_EVENT_STATUS:   prdata_next[7:0] = raw_cause;
      `OFF_FIFO_STATUS:
      begin
        prdata_next[`FST_EMPTY]          = f_empty;
        prdata_next[`FST_FULL]           = f_full;
        prdata_next[`FST_OTHER_LSB +: 8] = other_fifo_flags;
        prdata_next[`FST_FILL_LSB +: 7]  = fill;
        prdata_next[`FST_LEVEL_LSB +: 2] = levels;
      end
      `OFF_IDLE_TIMER:     prdata_next[15:0] = idle_reg;
      `OFF_EP1_DATA:       prdata_next[7:0] = fifo_mem[rd_ptr_reg[5:0]];
      default:             prdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      prdata_reg <= 32'h0000_0000;
    else if (setup_ph && !pwrite)
      prdata_reg <= prdata_next;
  end

endmodule // usb_endpoint_interrupt_status

`default_nettype wire

// ==== rtl/usb_irq_defines.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the
//          endpoint interrupt and status block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
// Summary of operation
// RULE1: Any pending enabled cause drives the single interrupt request output.
// RULE2: Eight causes: setup, ctrl rx, ctrl tx, ep1, ep2, ep3 tx, reset, suspend.
// RULE3: Cause status register shows which causes drive the interrupt line.
// RULE4: Each cause has its own enable bit, changeable at any time.
// RULE5: Setup-ready flag sets once an 8-byte setup packet is stored.
// RULE6: Cause bit 0 reads one only when enabled and setup-ready is set.
// RULE7: Writing one to setup-ready clears it and withdraws the interrupt.
// RULE8: A new setup packet during clearing keeps the interrupt asserted.
// RULE9: Control receive-ready bit 0 sets on error-free end of data packet.
// RULE10: End of packet completes reception for full and short packets alike.
// RULE11: Cause bit 3 reads one only when enabled and receive-ready is set.
// RULE12: Writing one to receive-ready bit 0 clears that flag.
// RULE13: Endpoint 1 has a 64-byte FIFO in two levels, either direction.
// RULE14: Software selects receive or transmit direction for endpoints 1 and 2.
// RULE15: Every endpoint FIFO reports full/empty and can rewind contents. Here only the endpoint 1 FIFO can rewind.
// RULE16: Only the endpoint 1 FIFO may be serviced by DMA.
// RULE17: A timer measures bus idle time to detect suspend.
// RULE18: Interrupt output is active low after reset, polarity programmable.
// RULE19: Flags stay set until cleared; output stays while enabled flag set.
`ifndef USB_IRQ_DEFINES_SVH
`define USB_IRQ_DEFINES_SVH

`define OFF_CAUSE_STATUS   8'h00
`define OFF_ENABLE_MASK    8'h04
`define OFF_CTRL_EP_STATUS 8'h08
`define OFF_PKT_READY      8'h0C
`define OFF_RX_BYTE_COUNT  8'h10
`define OFF_EP_CONFIG      8'h14
`define OFF_EVENT_STATUS   8'h18
`define OFF_EVENT_CLEAR    8'h1C
`define OFF_FIFO_STATUS    8'h20
`define OFF_FIFO_CONTROL   8'h24
`define OFF_IDLE_TIMER     8'h28
`define OFF_EP1_DATA       8'h2C

`define CAUSE_SETUP   0
`define CAUSE_EP1     1
`define CAUSE_EP2     2
`define CAUSE_CTRL_RX 3
`define CAUSE_CTRL_TX 4
`define CAUSE_EP3_TX  5
`define CAUSE_RESET   6
`define CAUSE_SUSPEND 7

`define PKT_CTRL_RX 0
`define PKT_EP1     1
`define PKT_EP2     2
`define PKT_CTRL_TX 4

`define CFG_EP1_TX     0
`define CFG_EP2_TX     1
`define CFG_IRQ_HIGH   2
`define CFG_EP1_DMA    3

`define FCTL_REWIND_RD 0
`define FCTL_REWIND_WR 1
`define FCTL_MARK      2

`define FST_EMPTY      0
`define FST_FULL       1
`define FST_OTHER_LSB  2
`define FST_FILL_LSB   10
`define FST_LEVEL_LSB  17

`define ENABLE_RESET   8'h00
`define CONFIG_RESET   4'h0

`define EP1_FIFO_BYTES 64
`define EP1_LEVEL_BYTES 32
`define CLOCK_MHZ      10
`define SUSPEND_IDLE_US 3000

`endif

// ==== rtl/usb_irq_pkg.sv ====
// Purpose: Types shared by the endpoint interrupt and status block.
// Assumes: Nothing beyond the defines header.
// Notes:   Types only.
package usb_irq_pkg;

  typedef struct packed {
    logic setup_done;
    logic ctrl_rx_done;
    logic ep1_done;
    logic ep2_done;
    logic ep3_tx_done;
    logic bus_reset;
    logic ctrl_tx_stage;
    logic ctrl_tx_acked;
    logic bus_idle;
  } usb_events_t;

  typedef struct packed {
    logic       push;
    logic [7:0] push_data;
    logic       pop;
  } ep1_usb_req_t;

  typedef struct packed {
    logic [7:0] head_data;
    logic       full;
    logic       empty;
  } ep1_usb_rsp_t;

endpackage

// ==== test/apb_fw_model.sv ====
// Purpose: Firmware side bus master.
// Assumes: Tasks called right after a rising edge.
// Notes:   Released address and data are inverted, not held.
`timescale 1ns/100ps
`default_nettype none
module apb_fw_model (
  input  wire logic        clock,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hFF;
    pwdata = 32'h0000_0000;
  end
  // Idle edge at the end so psel never changes twice at once
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clock);
  endtask
endmodule // apb_fw_model
`default_nettype wire

// ==== test/test_usb_endpoint_interrupt_status.sv ====
// Purpose: Self-checking bench for the interrupt and status block.
// Assumes: Suspend count shortened to 20 cycles.
// Notes:   Reads queue notes; a negedge monitor compares them.
`timescale 1ns/100ps
`default_nettype none
module test_usb_endpoint_interrupt_status;
  logic                      clock, arst_n, psel, penable, pwrite;
  logic                      pready, pslverr, irq;
  logic [7:0]                paddr, fifo_flags, c;
  logic [31:0]               pwdata, prdata;
  logic [3:0]                rx_cnt;
  usb_irq_pkg::usb_events_t  ev;
  usb_irq_pkg::ep1_usb_req_t ep1_req;
  logic [65:0]               note_q[$];
  logic [65:0]               note;
  int                        miscompares, tests_run, seed, i;
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  usb_endpoint_interrupt_status #(.SUSPEND_IDLE_CYCLES(20)) dut_u (.clock(clock),
    .arst_n(arst_n), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .usb_ev(ev), .ctrl_rx_count(rx_cnt),
    .other_fifo_flags(fifo_flags), .ep1_usb_req(ep1_req), .ep1_usb_rsp(),
    .endpoint_tx_dir(), .dma_request(), .dma_ack(1'b0), .dma_wdata(8'h00),
    .dma_rdata(), .interrupt_request_out(irq));
  apb_fw_model fw_u (.clock(clock), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d,
                    input logic q, input logic e);
    note_q.push_back({e, q, m, d});
    fw_u.xfer(1'b0, a, 32'h0000_0000);
  endtask
  task automatic pulse(input usb_irq_pkg::usb_events_t e);
    ev <= e;
    @(posedge clock);
    ev <= '0;
    repeat (2) @(posedge clock);
  endtask
  always @(negedge clock)
  begin
    if (psel && penable && !pwrite && note_q.size() > 0)
    begin
      note = note_q.pop_front();
      tests_run++;
      if ((prdata & note[63:32]) !== note[31:0] || irq !== note[64] || pslverr !== note[65])
      begin
        miscompares++;
        $display("wrong value at %0t: addr %h data %h", $time, paddr, prdata);
      end
    end
  end
  initial
  begin
    repeat (5000) @(posedge clock);
    miscompares++;
    wrap_up();
  end
  initial
  begin
    seed = 77677;
    arst_n = 1'b0;
    ev = '0;
    ep1_req = '0;
    rx_cnt = 4'h0;
    fifo_flags = 8'h00;
    miscompares = 0;
    tests_run = 0;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    fifo_flags <= 8'($random(seed));
    @(posedge clock);
    rd(8'h04, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1, 1'b0);
    rd(8'h20, 32'h0000_03FF, {22'h000000, fifo_flags, 2'h1}, 1'b1, 1'b0);
    fw_u.xfer(1'b1, 8'h04, 32'h0000_0009);
    rd(8'h04, 32'h0000_00FF, 32'h0000_0009, 1'b1, 1'b0);
    pulse(9'h100);
    rd(8'h00, 32'h0000_00FF, 32'h0000_0001, 1'b0, 1'b0);
    pulse(9'h100);
    rd(8'h00, 32'h0000_00FF, 32'h0000_0001, 1'b0, 1'b0);
    fw_u.xfer(1'b1, 8'h08, 32'h0000_0001);
    rd(8'h00, 32'h0000_00FF, 32'h0000_0000, 1'b1, 1'b0);
    fw_u.xfer(1'b1, 8'h04, 32'h0000_0008);
    pulse(9'h100);
    rd(8'h00, 32'h0000_00FF, 32'h0000_0000, 1'b1, 1'b0);
    fw_u.xfer(1'b1, 8'h08, 32'h0000_0001);
    // Full-size packet first, then short ones
    for (i = 0; i < 3; i++)
    begin
      rx_cnt <= (i == 0) ? 4'h8 : 4'($random(seed) & 7);
      pulse(9'h080);
      rd(8'h10, 32'h0000_000F, {28'h0000000, rx_cnt}, 1'b0, 1'b0);
      rd(8'h00, 32'h0000_00FF, 32'h0000_0008, 1'b0, 1'b0);
      fw_u.xfer(1'b1, 8'h0C, 32'h0000_0001);
      rd(8'h00, 32'h0000_00FF, 32'h0000_0000, 1'b1, 1'b0);
    end
    fw_u.xfer(1'b1, 8'h14, 32'h0000_0004);
    pulse(9'h080);
    rd(8'h00, 32'h0000_00FF, 32'h0000_0008, 1'b1, 1'b0);
    fw_u.xfer(1'b1, 8'h0C, 32'h0000_0001);
    rd(8'h00, 32'h0000_00FF, 32'h0000_0000, 1'b0, 1'b0);
    fw_u.xfer(1'b1, 8'h14, 32'h0000_0000);
    fw_u.xfer(1'b1, 8'h04, 32'h0000_00FF);
    // Endpoint 1, endpoint 2, endpoint 3 transmit, bus reset
    for (i = 0; i < 4; i++)
    begin
      c = (i < 2) ? 8'h02 << i : 8'h20 << (i - 2);
      pulse(9'h040 >> i);
      rd(8'h00, 32'h0000_00FF, {24'h000000, c}, 1'b0, 1'b0);
      fw_u.xfer(1'b1, 8'h1C, {24'h000000, c});
      fw_u.xfer(1'b1, 8'h0C, {24'h000000, c & 8'h06});
      rd(8'h00, 32'h0000_00FF, 32'h0000_0000, 1'b1, 1'b0);
    end
    ev <= 9'h004;
    repeat (2) @(posedge clock);
    rd(8'h00, 32'h0000_00FF, 32'h0000_0010, 1'b0, 1'b0);
    fw_u.xfer(1'b1, 8'h0C, 32'h0000_0010);
    rd(8'h00, 32'h0000_00FF, 32'h0000_0000, 1'b1, 1'b0);
    ev <= 9'h001;
    repeat (25) @(posedge clock);
    ev <= '0;
    rd(8'h00, 32'h0000_00FF, 32'h0000_0080, 1'b0, 1'b0);
    fw_u.xfer(1'b1, 8'h1C, 32'h0000_0080);
    rd(8'h00, 32'h0000_00FF, 32'h0000_0000, 1'b1, 1'b0);
    rd(8'h30, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1, 1'b1);
    rd(8'h02, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1, 1'b1);
    // One push beyond full must be ignored
    for (i = 0; i < 65; i++)
    begin
      ep1_req <= {1'b1, 8'(i), 1'b0};
      @(posedge clock);
    end
    ep1_req <= '0;
    @(posedge clock);
    rd(8'h20, 32'h0007_FC03, 32'h0005_0002, 1'b1, 1'b0);
    // Data port pops the oldest bytes; rewinding to the reset mark replays them
    rd(8'h2C, 32'h0000_00FF, 32'h0000_0000, 1'b1, 1'b0);
    rd(8'h2C, 32'h0000_00FF, 32'h0000_0001, 1'b1, 1'b0);
    fw_u.xfer(1'b1, 8'h24, 32'h0000_0001);
    rd(8'h2C, 32'h0000_00FF, 32'h0000_0000, 1'b1, 1'b0);
    wrap_up();
  end
endmodule // test_usb_endpoint_interrupt_status
`default_nettype wire

// ==== test/usb_irq_chk.sv ====
// Purpose: Port assertions for the interrupt and status block.
// Assumes: ce held high.
// Notes:   Shadows enable, polarity and two flags from bus writes.
`timescale 1ns/100ps
`default_nettype none
module usb_irq_chk (
  input wire logic                     clock,
  input wire logic                     arst_n,
  input wire logic                     ce,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [7:0]               paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire usb_irq_pkg::usb_events_t usb_ev,
  input wire logic [3:0]               ctrl_rx_count,
  input wire logic                     interrupt_request_out
);
  logic [7:0] en_reg;
  logic [3:0] cnt_reg;
  logic       pol_reg;
  logic       sf_reg;
  logic       rf_reg;
  logic       acc;
  logic       wr;
  logic       ok;
  assign acc = psel && penable;
  assign wr = acc && pwrite && pready;
  assign ok = paddr <= 8'h2C && paddr[1:0] == 2'h0;
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      en_reg <= 8'h00;
      cnt_reg <= 4'h0;
      pol_reg <= 1'b0;
      sf_reg <= 1'b0;
      rf_reg <= 1'b0;
    end
    else
    begin
      if (wr && paddr == 8'h04) en_reg <= pwdata[7:0];
      if (wr && paddr == 8'h14) pol_reg <= pwdata[2];
      if (usb_ev.ctrl_rx_done) cnt_reg <= ctrl_rx_count;
      // Set beats clear
      if (usb_ev.setup_done) sf_reg <= 1'b1;
      else if (wr && (paddr == 8'h08 || paddr == 8'h1C) && pwdata[0]) sf_reg <= 1'b0;
      if (usb_ev.ctrl_rx_done) rf_reg <= 1'b1;
      else if (wr && (paddr == 8'h0C && pwdata[0] || paddr == 8'h1C && pwdata[3]))
        rf_reg <= 1'b0;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_pready_ce: assert property (pready == ce)
    else $error("pready differs from ce");
  a_bad_addr_err: assert property (acc && !ok |-> pslverr)
    else $error("no error on unmapped access");
  a_good_addr_ok: assert property (acc && ok |-> !pslverr)
    else $error("error on mapped access");
  a_irq_reset_idle: assert property ($rose(arst_n) |-> interrupt_request_out [*2])
    else $error("interrupt active after reset");
  // Only setup and control receive causes enabled, low polarity
  a_irq_follows_flags: assert property ((en_reg & 8'hF6) == 8'h00 && !pol_reg
    |=> interrupt_request_out == !$past(sf_reg && en_reg[0] || rf_reg && en_reg[3]))
    else $error("interrupt output does not follow flags");
  a_cause_read: assert property (acc && !pwrite && paddr == 8'h00
    |-> prdata[0] == $past(sf_reg && en_reg[0]) && prdata[3] == $past(rf_reg && en_reg[3]))
    else $error("cause status wrong");
  a_enable_read: assert property (acc && !pwrite && paddr == 8'h04
    |-> prdata[7:0] == $past(en_reg))
    else $error("enable readback wrong");
  a_count_read: assert property (acc && !pwrite && paddr == 8'h10
    |-> prdata[3:0] == $past(cnt_reg))
    else $error("byte count wrong");
  c_setup: cover property (usb_ev.setup_done ##2 !interrupt_request_out);
  c_rx: cover property (usb_ev.ctrl_rx_done && en_reg[3]);
  c_err: cover property (acc && pslverr);
endmodule // usb_irq_chk
bind usb_endpoint_interrupt_status usb_irq_chk chk_u (.clock(clock), .arst_n(arst_n),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .usb_ev(usb_ev), .ctrl_rx_count(ctrl_rx_count),
  .interrupt_request_out(interrupt_request_out));
`default_nettype wire
